// ==== src/fsr_defines.svh ====
// Constants shared by both ends of the flow-through burst SRAM link.
// Assumes inclusion by bare name from files under src/.
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

`define FSR_ADDR_W 18
`define FSR_DATA_W 18
`define FSR_LANE_W 9
`define FSR_LANES 2
`define FSR_DEPTH 262144
`define FSR_BURST_W 2
`define FSR_LANE_A_LSB 0
`define FSR_LANE_B_LSB 9
`define FSR_RST_ADDR 18'h00000
`define FSR_RST_DATA 18'h00000
`define FSR_RST_BW_N 2'h3
`define FSR_RST_BURST 2'h0
`define FSR_BUS_IDLE 18'h00000

`endif

// ==== src/fsr_pkg.sv ====
// Types shared by the SRAM end and the controller end.
// Assumes fsr_defines.svh is on the include path.
`include "fsr_defines.svh"

package fsr_pkg;

  typedef logic [`FSR_ADDR_W-1:0] fsr_addr_type;
  typedef logic [`FSR_DATA_W-1:0] fsr_data_type;
  typedef logic [`FSR_LANES-1:0] fsr_lane_type;
  typedef logic [`FSR_BURST_W-1:0] fsr_burst_type;

  // Registered command and burst position inside the SRAM
  typedef struct packed {
    logic sel;
    logic wr;
    fsr_addr_type base;
    fsr_burst_type cnt;
    fsr_lane_type bw_n;
  } fsr_sram_state_type;

  // Controller pin stage, data stage and read result
  typedef struct packed {
    logic cen_n;
    logic cs1_n;
    logic cs2;
    logic cs3_n;
    logic we_n;
    logic adv;
    fsr_addr_type addr;
    fsr_lane_type bw_n;
    logic c_valid;
    logic c_write;
    fsr_data_type c_wdata;
    logic d_read;
    logic d_write;
    fsr_data_type d_wdata;
    logic rd_valid;
    fsr_data_type rd_data;
  } fsr_ctrl_state_type;

endpackage

// ==== src/fsr_if.sv ====
// Pin-level link between the burst SRAM and its controller.
// The shared data bus is resolved here from the two output enables.
`timescale 1ns/1ps
`include "fsr_defines.svh"

interface fsr_if
  import fsr_pkg::*;
();
  fsr_addr_type addr;
  logic advance_or_load;
  logic write_enable_n;
  fsr_lane_type byte_lane_write_n;
  logic chip_select_first_n;
  logic chip_select_second;
  logic chip_select_third_n;
  logic clock_qualifier_n;
  logic output_enable_n;
  logic sleep_request;
  fsr_data_type dq_ctrl_out;
  logic dq_ctrl_oe;
  fsr_data_type dq_sram_out;
  logic dq_sram_oe;
  fsr_data_type dq;

  // Undriven bus rests at a fixed level; the SRAM end wins if both enables are on
  assign dq = dq_sram_oe ? dq_sram_out : (dq_ctrl_oe ? dq_ctrl_out : `FSR_BUS_IDLE);

  modport sram (
    input addr, advance_or_load, write_enable_n, byte_lane_write_n,
    input chip_select_first_n, chip_select_second, chip_select_third_n,
    input clock_qualifier_n, output_enable_n, sleep_request, dq,
    output dq_sram_out, dq_sram_oe
  );

  modport ctrl (
    output addr, advance_or_load, write_enable_n, byte_lane_write_n,
    output chip_select_first_n, chip_select_second, chip_select_third_n,
    output clock_qualifier_n, output_enable_n, sleep_request,
    output dq_ctrl_out, dq_ctrl_oe,
    input dq
  );
endinterface

// ==== src/fsr_sram.sv ====
// SRAM end: 256K x 18 flow-through burst memory with registered inputs.
// Assumes one clock shared with the controller and a resolved dq bus.
`timescale 1ns/1ps
`include "fsr_defines.svh"

module fsr_sram
  import fsr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic BURST_LINEAR,
  fsr_if.sram LINK
);

  fsr_sram_state_type st_reg;
  fsr_sram_state_type st_next;
  fsr_data_type mem [`FSR_DEPTH];
  fsr_addr_type word_addr;
  logic clk_ok;
  logic select_hit;
  logic [`FSR_LANE_W-1:0] lane_data [`FSR_LANES];
  logic [`FSR_LANES-1:0] lane_we;
  logic data_phase_write;
  logic read_phase;
  fsr_data_type rd_word;

  // Kind of link command presented at an edge
  typedef enum logic [2:0] {
    CMD_STALL = 3'b000,
    CMD_DESELECT = 3'b001,
    CMD_READ = 3'b010,
    CMD_WRITE = 3'b011,
    CMD_ADVANCE = 3'b100
  } fsr_cmd_type;

  fsr_cmd_type cmd;

  // Low word address for burst position, from start bits and counter
  function automatic fsr_burst_type burst_low(
    input fsr_burst_type start,
    input fsr_burst_type cnt,
    input logic linear
  );
    if (linear)
    begin
      burst_low = fsr_burst_type'(start + cnt);
    end
    else
    begin
      burst_low = start ^ cnt;
    end
  endfunction

  // Byte lane field of a data word
  function automatic logic [`FSR_LANE_W-1:0] lane_of(
    input fsr_data_type d,
    input int lane
  );
    lane_of = d[lane*`FSR_LANE_W +: `FSR_LANE_W];
  endfunction

  // Bank select: first low, second high, third low, not asleep
  function automatic logic bank_hit(
    input logic first_n,
    input logic second,
    input logic third_n,
    input logic asleep
  );
    bank_hit = ~first_n & second & ~third_n & ~asleep;
  endfunction

  // Command from qualifier, advance, bank select and write enable
  function automatic fsr_cmd_type decode_cmd(
    input logic qual_n,
    input logic adv,
    input logic hit,
    input logic we_n
  );
    if (qual_n)
    begin
      decode_cmd = CMD_STALL;
    end
    else if (adv)
    begin
      decode_cmd = CMD_ADVANCE;
    end
    else if (!hit)
    begin
      decode_cmd = CMD_DESELECT;
    end
    else if (!we_n)
    begin
      decode_cmd = CMD_WRITE;
    end
    else
    begin
      decode_cmd = CMD_READ;
    end
  endfunction

  assign clk_ok = ~LINK.clock_qualifier_n;
  assign select_hit = bank_hit(LINK.chip_select_first_n, LINK.chip_select_second,
    LINK.chip_select_third_n, LINK.sleep_request);
  assign cmd = decode_cmd(LINK.clock_qualifier_n, LINK.advance_or_load, select_hit,
    LINK.write_enable_n);
  assign word_addr = {st_reg.base[`FSR_ADDR_W-1:`FSR_BURST_W],
    burst_low(st_reg.base[`FSR_BURST_W-1:0], st_reg.cnt, BURST_LINEAR)};

  always_comb
  begin
    st_next = st_reg;
    case (cmd)
      CMD_STALL:
      begin
        st_next = st_reg;
      end
      CMD_ADVANCE:
      begin
        st_next.bw_n = LINK.byte_lane_write_n;
        if (st_reg.sel)
        begin
          st_next.cnt = fsr_burst_type'(st_reg.cnt + 2'h1);
        end
      end
      CMD_DESELECT:
      begin
        st_next.bw_n = LINK.byte_lane_write_n;
        st_next.sel = 1'b0;
        st_next.wr = ~LINK.write_enable_n;
        st_next.base = LINK.addr;
        st_next.cnt = `FSR_RST_BURST;
      end
      CMD_READ, CMD_WRITE:
      begin
        st_next.bw_n = LINK.byte_lane_write_n;
        st_next.sel = 1'b1;
        st_next.wr = (cmd == CMD_WRITE);
        st_next.base = LINK.addr;
        st_next.cnt = `FSR_RST_BURST;
      end
      default:
      begin
        st_next = st_reg;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_reg.sel <= 1'b0;
      st_reg.wr <= 1'b0;
      st_reg.base <= `FSR_RST_ADDR;
      st_reg.cnt <= `FSR_RST_BURST;
      st_reg.bw_n <= `FSR_RST_BW_N;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Write strobe for the data phase of a selected write
  assign data_phase_write = clk_ok & st_reg.sel & st_reg.wr;

  // Lane split of incoming write data and per-lane strobes
  for (genvar i = 0; i < `FSR_LANES; i++)
  begin : g_lane
    assign lane_data[i] = lane_of(LINK.dq, i);
    assign lane_we[i] = data_phase_write & ~st_reg.bw_n[i];
  end

  // Self-timed write at the edge closing the write data phase
  always_ff @(posedge CLK)
  begin
    for (int i = 0; i < `FSR_LANES; i++)
    begin
      if (!RST && lane_we[i])
      begin
        mem[word_addr][i*`FSR_LANE_W +: `FSR_LANE_W] <= lane_data[i];
      end
    end
  end

  // Flow-through read of the registered address
  assign rd_word = mem[word_addr];
  assign LINK.dq_sram_out = rd_word;

  // Drivers on only in a selected read phase, gated without a clock
  assign read_phase = st_reg.sel & ~st_reg.wr;
  assign LINK.dq_sram_oe = read_phase & ~LINK.output_enable_n;

endmodule

// ==== src/fsr_ctrl.sv ====
// Controller end: drives SRAM pins from flip-flops, except output enable and sleep which pass straight from inputs; one command a cycle.
// Assumes the SRAM shares CLK; HOLD stalls both ends through the qualifier.
`timescale 1ns/1ps
`include "fsr_defines.svh"

module fsr_ctrl
  import fsr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic HOLD,
  input wire logic OUT_ENABLE,
  input wire logic SLEEP,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_BURST,
  input wire fsr_addr_type REQ_ADDR,
  input wire fsr_lane_type REQ_BYTE_EN,
  input wire fsr_data_type REQ_WDATA,
  output logic REQ_READY,
  output logic RD_VALID,
  output fsr_data_type RD_DATA,
  fsr_if.ctrl LINK
);

  fsr_ctrl_state_type st_reg;
  fsr_ctrl_state_type st_next;
  logic moving;

  // SRAM sees an edge only while the driven qualifier is low
  assign moving = ~st_reg.cen_n;
  assign REQ_READY = moving;

  always_comb
  begin
    st_next = st_reg;
    st_next.cen_n = HOLD;
    st_next.rd_valid = 1'b0;
    if (moving)
    begin
      st_next.d_read = st_reg.c_valid & ~st_reg.c_write;
      st_next.d_write = st_reg.c_valid & st_reg.c_write;
      st_next.d_wdata = st_reg.c_wdata;
      st_next.rd_valid = st_reg.d_read;
      if (st_reg.d_read)
      begin
        st_next.rd_data = LINK.dq;
      end
      st_next.c_valid = REQ_VALID;
      st_next.c_write = REQ_WRITE;
      st_next.c_wdata = REQ_WDATA;
      st_next.adv = REQ_VALID & REQ_BURST;
      st_next.cs1_n = ~REQ_VALID;
      st_next.cs2 = REQ_VALID;
      st_next.cs3_n = ~REQ_VALID;
      st_next.we_n = ~(REQ_VALID & REQ_WRITE);
      st_next.bw_n = ~(REQ_BYTE_EN & {`FSR_LANES{REQ_VALID & REQ_WRITE}});
      st_next.addr = REQ_ADDR;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_reg <= '0;
      st_reg.cs1_n <= 1'b1;
      st_reg.cs3_n <= 1'b1;
      st_reg.we_n <= 1'b1;
      st_reg.bw_n <= `FSR_RST_BW_N;
      st_reg.addr <= `FSR_RST_ADDR;
      st_reg.c_wdata <= `FSR_RST_DATA;
      st_reg.d_wdata <= `FSR_RST_DATA;
      st_reg.rd_data <= `FSR_RST_DATA;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign LINK.clock_qualifier_n = st_reg.cen_n;
  assign LINK.chip_select_first_n = st_reg.cs1_n;
  assign LINK.chip_select_second = st_reg.cs2;
  assign LINK.chip_select_third_n = st_reg.cs3_n;
  assign LINK.write_enable_n = st_reg.we_n;
  assign LINK.advance_or_load = st_reg.adv;
  assign LINK.addr = st_reg.addr;
  assign LINK.byte_lane_write_n = st_reg.bw_n;
  assign LINK.output_enable_n = ~OUT_ENABLE;
  assign LINK.sleep_request = SLEEP;
  assign LINK.dq_ctrl_out = st_reg.d_wdata;
  assign LINK.dq_ctrl_oe = st_reg.d_write;
  assign RD_VALID = st_reg.rd_valid;
  assign RD_DATA = st_reg.rd_data;

endmodule

// ==== testbench/fsr_link_chk.sv ====
// Checker on the link pins between the SRAM end and the controller end.
// Assumes the bench ties each input to the matching link signal.
`timescale 1ns/1ps
module fsr_link_chk
  import fsr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic advance_or_load,
  input wire logic write_enable_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic clock_qualifier_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic dq_ctrl_oe,
  input wire logic dq_sram_oe
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire ld = !clock_qualifier_n && !advance_or_load;
  wire on = !chip_select_first_n && chip_select_second && !chip_select_third_n && !sleep_request;
  property p_excl; !(dq_sram_oe && dq_ctrl_oe); endproperty
  a_excl: assert property (p_excl) else $error("both ends drive");
  property p_oe; output_enable_n |-> !dq_sram_oe; endproperty
  a_oe: assert property (p_oe) else $error("drive without oe");
  property p_desel; ld && !on |=> !dq_sram_oe; endproperty
  a_desel: assert property (p_desel) else $error("drive deselected");
  property p_wr_off; ld && on && !write_enable_n |=> !dq_sram_oe; endproperty
  a_wr_off: assert property (p_wr_off) else $error("drive in write");
  property p_wr_data; ld && on && !write_enable_n |=> dq_ctrl_oe; endproperty
  a_wr_data: assert property (p_wr_data) else $error("no write data");
  property p_rd; ld && on && write_enable_n ##1 !output_enable_n |-> dq_sram_oe; endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_hold; clock_qualifier_n ##1 $stable(output_enable_n) |-> $stable(dq_sram_oe); endproperty
  a_hold: assert property (p_hold) else $error("moved in stall");
  property p_src; $rose(dq_ctrl_oe) |-> !$past(write_enable_n); endproperty
  a_src: assert property (p_src) else $error("data without write");
endmodule

// ==== testbench/test_sync_flow_through_burst_sram.sv ====
// Bench joining the SRAM end and the controller end over one link.
// Assumes the src package, header and interface are compiled first.
`timescale 1ns/1ps
module test_sync_flow_through_burst_sram;
  import fsr_pkg::*;
  logic clk = 0, rst = 1, hold = 0, oe = 1, slp = 0, lin = 1, v = 0, w = 0, b = 0;
  logic rdy, rdv, lt = 0, hv = 0;
  fsr_addr_type a = '0;
  fsr_lane_type be = '0;
  fsr_data_type wd = '0, rdd, mem [16], q [$];
  logic [31:0] sd = 32'h5e3ac7a0, r;
  logic [3:0] base = '0;
  logic [1:0] cnt = '0;
  int n_errors = 0, cmp_count = 0;
  always #4 clk = ~clk;
  fsr_if lnk ();
  fsr_sram i_fsr_sram (.CLK(clk), .RST(rst), .BURST_LINEAR(lin), .LINK(lnk));
  fsr_ctrl i_fsr_ctrl (.CLK(clk), .RST(rst), .HOLD(hold), .OUT_ENABLE(oe), .SLEEP(slp),
    .REQ_VALID(v), .REQ_WRITE(w), .REQ_BURST(b), .REQ_ADDR(a), .REQ_BYTE_EN(be),
    .REQ_WDATA(wd), .REQ_READY(rdy), .RD_VALID(rdv), .RD_DATA(rdd), .LINK(lnk));
  fsr_link_chk i_fsr_link_chk (.CLK(clk), .RST(rst),
    .advance_or_load(lnk.advance_or_load), .write_enable_n(lnk.write_enable_n),
    .chip_select_first_n(lnk.chip_select_first_n), .chip_select_second(lnk.chip_select_second),
    .chip_select_third_n(lnk.chip_select_third_n), .clock_qualifier_n(lnk.clock_qualifier_n),
    .output_enable_n(lnk.output_enable_n), .sleep_request(lnk.sleep_request),
    .dq_ctrl_oe(lnk.dq_ctrl_oe), .dq_sram_oe(lnk.dq_sram_oe));
  function automatic logic [31:0] rnd();
    sd = sd ^ (sd << 13);
    sd = sd ^ (sd >> 17);
    sd = sd ^ (sd << 5);
    return sd;
  endfunction
  function automatic fsr_data_type mrg(fsr_data_type m, d, fsr_lane_type e);
    return {e[1] ? d[17:9] : m[17:9], e[0] ? d[8:0] : m[8:0]};
  endfunction
  function automatic logic [3:0] bix(logic [3:0] s, logic [1:0] c);
    return {s[3:2], lin ? s[1:0] + c : s[1:0] ^ c};
  endfunction
  task automatic check(input fsr_data_type s, x);
    cmp_count++;
    if (s !== x)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One request, stall pulse drawn at random for the next one
  task automatic req(input logic ww, bb, input logic [3:0] ix, input fsr_lane_type e);
    fsr_data_type d;
    int k;
    d = fsr_data_type'(rnd());
    v <= 1;
    w <= ww;
    b <= bb;
    a <= {14'h3fff, ix};
    be <= e;
    wd <= d;
    k = 0;
    do
    begin
      hold <= (k == 0) && (rnd() % 5 == 0);
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    if (bb) cnt = cnt + 1;
    else
    begin
      base = ix;
      cnt = 0;
    end
    ix = bix(base, cnt);
    lt = ww;
    hv = 1;
    if (!ww) q.push_back(oe ? mem[ix] : '0);
    else if (!slp) mem[ix] = mrg(mem[ix], d, e);
  endtask
  task automatic idle(input int n);
    v <= 0;
    hold <= 0;
    hv = 0;
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk)
    if (rdv === 1'b1) check(rdd, q.size() > 0 ? q.pop_front() : 'x);
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 16; i++) req(1, 0, i, 2'h3);
    for (int p = 0; p < 2; p++)
    begin
      idle(3);
      lin <= !p[0];
      for (int n = 0; n < 300; n++)
      begin
        r = rnd();
        req(r[0], hv && lt == r[0] && cnt != 3 && r[2:1] != 0, r[6:3], r[8:7]);
      end
    end
    idle(4);
    slp <= 1;
    for (int i = 0; i < 16; i += 3) req(1, 0, i, 2'h3);
    idle(6);
    slp <= 0;
    oe <= 0;
    for (int i = 0; i < 4; i++) req(0, 0, i, 2'h0);
    idle(4);
    oe <= 1;
    for (int i = 0; i < 16; i++) req(0, 0, i, 2'h0);
    idle(10);
    check(fsr_data_type'(q.size()), '0);
    conclude();
  end
  initial
  begin
    #200000;
    n_errors++;
    conclude();
  end
endmodule
